// ---- tpg_stage.sv ----
// Purpose: Prediction gain tone test, frame windowing, flag packing
// Assumes: Reflection coefficients and samples synchronous to ref_clk
// Notes:   One frame start pulse per 160-sample frame
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"

module tpg_stage #(
	parameter bit DOWNLINK = 1'b1
) (
	input  wire logic               ref_clk,
	input  wire logic               arst_n,
	input  wire logic               frame_start,
	input  wire tpg_pkg::tpg_word_t reflection_coefficient_1,
	input  wire tpg_pkg::tpg_word_t reflection_coefficient_2,
	input  wire tpg_pkg::tpg_word_t reflection_coefficient_3,
	input  wire tpg_pkg::tpg_word_t reflection_coefficient_4,
	input  wire logic               low_pole,
	output logic                    tone,
	output logic                    tone_valid,
	input  wire logic               sample_valid,
	input  wire logic [7:0]         sample_index,
	input  wire tpg_pkg::tpg_word_t sample,
	output tpg_pkg::tpg_word_t      windowed_sample,
	output logic                    windowed_valid,
	output logic [7:0]              windowed_index,
	input  wire logic               pack_valid,
	input  wire logic               activity_flag,
	input  wire logic               speech_frame_flag,
	input  wire logic [15:0]        first_encoded_parameter_in,
	input  wire logic [15:0]        second_encoded_parameter_in,
	output logic [15:0]             first_encoded_parameter,
	output logic [15:0]             second_encoded_parameter,
	output logic                    pack_out_valid
);
	import tpg_pkg::*;

	// ************************************************
	// Arithmetic
	// ************************************************
	function automatic tpg_word_t sat16(input logic signed [31:0] v);
		if (v > 32'sd32767) begin
			return 16'sh7FFF;
		end else if (v < -32'sd32768) begin
			return 16'sh8000;
		end
		return tpg_word_t'(v[15:0]);
	endfunction

	// Fractional product, truncating or rounding
	function automatic tpg_word_t fmul(input tpg_word_t a, input tpg_word_t b,
		input logic rnd);
		logic signed [31:0] p;
		p = 32'(a) * 32'(b);
		if (rnd) begin
			p = p + 32'sh0000_4000;
		end
		return sat16(p >>> 15);
	endfunction

	function automatic tpg_word_t ssub(input tpg_word_t a, input tpg_word_t b);
		return sat16(32'(a) - 32'(b));
	endfunction

	// ************************************************
	// Prediction gain sequencer
	// ************************************************
	tpg_state_e state_reg;
	tpg_word_t  refl_reg [0:3];
	tpg_word_t  prederr_reg;
	logic [2:0] step_reg;
	tpg_word_t  prederr_next;
	tpg_word_t  refl_cur;

	always_comb begin
		refl_cur     = refl_reg[step_reg[1:0]];
		prederr_next = fmul(prederr_reg,
			ssub(`TPG_FULL_SCALE, fmul(refl_cur, refl_cur, 1'b0)), 1'b0);
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			state_reg   <= TPG_IDLE;
			prederr_reg <= 16'sh0000;
			step_reg    <= 3'h0;
			for (int k = 0; k < 4; k++) begin
				refl_reg[k] <= 16'sh0000;
			end
		end else begin
			case (state_reg)
				TPG_IDLE: begin
					if (frame_start && DOWNLINK && !low_pole) begin
						refl_reg[0] <= reflection_coefficient_1;
						refl_reg[1] <= reflection_coefficient_2;
						refl_reg[2] <= reflection_coefficient_3;
						refl_reg[3] <= reflection_coefficient_4;
						state_reg <= TPG_LOAD;
					end
				end
				TPG_LOAD: begin
					prederr_reg <= `TPG_FULL_SCALE;
					step_reg    <= 3'h0;
					state_reg   <= TPG_MULT;
				end
				TPG_MULT: begin
					prederr_reg <= prederr_next;
					step_reg    <= step_reg + 3'h1;
					if (step_reg == `TPG_NUM_COEF - 3'h1) begin
						state_reg <= TPG_DONE;
					end
				end
				TPG_DONE: begin
					state_reg <= TPG_IDLE;
				end
				default: begin
					state_reg <= TPG_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			tone       <= 1'b0;
			tone_valid <= 1'b0;
		end else if (!DOWNLINK) begin
			tone       <= 1'b0;
			tone_valid <= frame_start;
		end else if (frame_start && low_pole) begin
			tone       <= 1'b0;
			tone_valid <= 1'b1;
		end else if (state_reg == TPG_DONE) begin
			tone       <= ssub(prederr_reg, `TPG_TONE_THRESH) < 0;
			tone_valid <= 1'b1;
		end else begin
			tone_valid <= 1'b0;
		end
	end

	// ************************************************
	// Symmetric windowing
	// ************************************************
	logic [6:0] win_index;
	tpg_word_t  win_coef;
	tpg_word_t  sample_reg;
	logic       sample_valid_reg;
	logic [7:0] sample_index_reg;

	// Mirror upper half onto the table
	assign win_index = (sample_index < 8'(`TPG_WIN_LEN)) ? sample_index[6:0] :
		7'(`TPG_FRAME_LAST - sample_index);

	// Window table lookup
	tpg_window_rom u_rom (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.index   (win_index),
		.coef    (win_coef)
	);

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			sample_reg       <= 16'sh0000;
			sample_valid_reg <= 1'b0;
			sample_index_reg <= 8'h00;
			windowed_sample  <= 16'sh0000;
			windowed_valid   <= 1'b0;
			windowed_index   <= 8'h00;
		end else begin
			sample_reg       <= sample;
			sample_valid_reg <= sample_valid && sample_index <= `TPG_FRAME_LAST;
			sample_index_reg <= sample_index;
			windowed_sample  <= fmul(sample_reg, win_coef, 1'b1);
			windowed_valid   <= sample_valid_reg;
			windowed_index   <= sample_index_reg;
		end
	end

	// ************************************************
	// Flag packing
	// ************************************************
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			first_encoded_parameter  <= 16'h0000;
			second_encoded_parameter <= 16'h0000;
			pack_out_valid           <= 1'b0;
		end else begin
			pack_out_valid <= pack_valid;
			if (pack_valid) begin
				first_encoded_parameter  <= {activity_flag,
					first_encoded_parameter_in[14:0]};
				second_encoded_parameter <= {speech_frame_flag,
					second_encoded_parameter_in[14:0]};
			end
		end
	end

	// ************************************************
	// Checks
	// ************************************************
	chk_tone_uplink_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!DOWNLINK |-> !tone)
		else $error("Uplink tone not zero");
	chk_low_pole_force: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(DOWNLINK && frame_start && low_pole) |=> (tone_valid && !tone))
		else $error("Low pole did not clear tone");
	chk_gain_latency: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(DOWNLINK && state_reg == TPG_IDLE && frame_start && !low_pole)
		|=> ##6 tone_valid)
		else $error("Tone result late");
	chk_tone_zero_coef: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(DOWNLINK && state_reg == TPG_IDLE && frame_start && !low_pole &&
		reflection_coefficient_1 == 0 && reflection_coefficient_2 == 0 &&
		reflection_coefficient_3 == 0 && reflection_coefficient_4 == 0)
		|=> ##6 !tone)
		else $error("Flat spectrum flagged as tone");
	chk_tone_threshold: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == TPG_DONE) |=> (tone == ($past(prederr_reg) < 16'sh05B8)))
		else $error("Tone threshold wrong");
	chk_step_count: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(state_reg == TPG_LOAD) |=>
		(state_reg == TPG_MULT) [*4] ##1 (state_reg == TPG_DONE))
		else $error("Wrong number of error products");
	chk_downlink_only: assert property (@(posedge ref_clk) disable iff (!arst_n)
		!DOWNLINK |-> state_reg == TPG_IDLE)
		else $error("Uplink ran tone logic");
	chk_pack_first: assert property (@(posedge ref_clk) disable iff (!arst_n)
		pack_valid |=> first_encoded_parameter[15] == $past(activity_flag))
		else $error("Activity bit wrong");
	chk_pack_second: assert property (@(posedge ref_clk) disable iff (!arst_n)
		pack_valid |=> second_encoded_parameter[15] == $past(speech_frame_flag))
		else $error("Speech bit wrong");
	chk_window_zero: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(sample_valid && (sample_index == 8'h00 || sample_index == 8'h9F))
		|=> ##1 windowed_sample == 16'sh0000)
		else $error("Window edge not zero");

	cov_tone_set: cover property (@(posedge ref_clk) tone_valid && tone);
	cov_tone_clear: cover property (@(posedge ref_clk) tone_valid && !tone);
	cov_low_pole: cover property (@(posedge ref_clk) frame_start && low_pole);
	cov_window_mid: cover property (@(posedge ref_clk) windowed_valid && windowed_index == 8'h50);

endmodule
`default_nettype wire

// ---- tpg_cfg.svh ----
// Purpose: Constants for the tone prediction gain stage
// Assumes: 16-bit fractional samples and coefficients
// Notes:   Included by the package users; definitions only
`ifndef TPG_CFG_SVH
`define TPG_CFG_SVH

`define TPG_FULL_SCALE   16'sh7FFF
`define TPG_TONE_THRESH  16'sh05B8
`define TPG_NUM_COEF     3'h4
`define TPG_WIN_LEN      7'h50
`define TPG_FRAME_LAST   8'h9F
`define TPG_MSB_POS      15

`endif

// ---- tpg_pkg.sv ----
// Purpose: Types for the tone prediction gain stage
// Assumes: Constants come from tpg_cfg.svh
// Notes:   One-hot state codes are written out
package tpg_pkg;

	typedef logic signed [15:0] tpg_word_t;

	typedef enum logic [3:0] {
		TPG_IDLE = 4'b0001,
		TPG_LOAD = 4'b0010,
		TPG_MULT = 4'b0100,
		TPG_DONE = 4'b1000
	} tpg_state_e;

endpackage

// ---- tpg_window_rom.sv ----
// Purpose: Window coefficient table, 80 entries, registered read
// Assumes: Index below 80; larger indices read as zero
// Notes:   One cycle read latency
`timescale 1ns/1ps
`default_nettype none
`include "tpg_cfg.svh"

module tpg_window_rom (
	input  wire logic           ref_clk,
	input  wire logic           arst_n,
	input  wire logic [6:0]     index,
	output var  tpg_pkg::tpg_word_t coef
);
	import tpg_pkg::*;

	localparam logic [15:0] WIN_TABLE [0:79] = '{
		16'h0000, 16'h000C, 16'h0033, 16'h0072, 16'h00CC, 16'h013E, 16'h01CA, 16'h026E,
		16'h032B, 16'h0401, 16'h04EE, 16'h05F3, 16'h070F, 16'h0842, 16'h098C, 16'h0AEB,
		16'h0C5F, 16'h0DE8, 16'h0F84, 16'h1135, 16'h12F8, 16'h14CD, 16'h16B3, 16'h18AA,
		16'h1AB0, 16'h1CC5, 16'h1EE9, 16'h2119, 16'h2356, 16'h259F, 16'h27F2, 16'h2A4F,
		16'h2CB4, 16'h2F21, 16'h3195, 16'h340E, 16'h368C, 16'h390F, 16'h3B93, 16'h3E1A,
		16'h40A1, 16'h4328, 16'h45AE, 16'h4832, 16'h4AB2, 16'h4D2E, 16'h4FA5, 16'h5216,
		16'h547F, 16'h56E0, 16'h5938, 16'h5B86, 16'h5DC9, 16'h5FFF, 16'h622A, 16'h6446,
		16'h6654, 16'h6853, 16'h6A41, 16'h6C1F, 16'h6DEB, 16'h6FA5, 16'h714B, 16'h72DE,
		16'h745D, 16'h75C7, 16'h771B, 16'h7859, 16'h7981, 16'h7A91, 16'h7B8A, 16'h7C6C,
		16'h7D35, 16'h7DE6, 16'h7E7E, 16'h7EFD, 16'h7F63, 16'h7FB0, 16'h7FE3, 16'h7FFC
	};

	// Table read, constant contents
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			coef <= 16'sh0000;
		end else if (index < `TPG_WIN_LEN) begin
			coef <= tpg_word_t'(WIN_TABLE[index]);
		end else begin
			coef <= 16'sh0000;
		end
	end

	chk_rom_known_entry: assert property (@(posedge ref_clk) disable iff (!arst_n)
		(index == 7'h28) |=> (coef == 16'sh40A1))
		else $error("Window entry 40 wrong");

endmodule
`default_nettype wire

// ---- tpg_enc_model.sv ----
// Purpose: Encoder model feeding coefficients and samples
// Assumes: Tasks are called just after a rising edge
// Notes:   Released lines show inverted data
`timescale 1ns/1ps
`default_nettype none
module tpg_enc_model (
	input  wire logic               ref_clk,
	output var  logic               frame_start,
	output var  tpg_pkg::tpg_word_t reflection_coefficient_1,
	output var  tpg_pkg::tpg_word_t reflection_coefficient_2,
	output var  tpg_pkg::tpg_word_t reflection_coefficient_3,
	output var  tpg_pkg::tpg_word_t reflection_coefficient_4,
	output var  logic               low_pole,
	output var  logic               sample_valid,
	output var  logic [7:0]         sample_index,
	output var  tpg_pkg::tpg_word_t sample
);
	import tpg_pkg::*;
	// ****
	// Drivers
	// ****
	initial begin
		frame_start = 1'b0;
		reflection_coefficient_1 = 16'sh0000;
		reflection_coefficient_2 = 16'sh0000;
		reflection_coefficient_3 = 16'sh0000;
		reflection_coefficient_4 = 16'sh0000;
		low_pole = 1'b0;
		sample_valid = 1'b0;
		sample_index = 8'h00;
		sample = 16'sh0000;
	end
	task automatic send_frame(input tpg_word_t c [4], input logic lp);
		reflection_coefficient_1 = c[0];
		reflection_coefficient_2 = c[1];
		reflection_coefficient_3 = c[2];
		reflection_coefficient_4 = c[3];
		low_pole = lp;
		frame_start = 1'b1;
		@(posedge ref_clk) #10;
		frame_start = 1'b0;
		low_pole = ~lp;
		// Inverted coefficients once the frame is taken
		reflection_coefficient_1 = ~c[0];
		reflection_coefficient_2 = ~c[1];
		reflection_coefficient_3 = ~c[2];
		reflection_coefficient_4 = ~c[3];
	endtask
	task automatic send_sample(input logic [7:0] idx, input tpg_word_t s);
		sample_index = idx;
		sample = s;
		sample_valid = 1'b1;
		@(posedge ref_clk) #10;
		sample_valid = 1'b0;
		sample = ~s;
	endtask
endmodule
`default_nettype wire

// ---- testbench.sv ----
// Purpose: Self-checking bench for the tone prediction gain stage
// Assumes: Inputs change 10 ns after the rising edge
// Notes:   Second instance is an uplink build
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import tpg_pkg::*;
	logic       ref_clk, arst_n, frame_start, low_pole, tone, tone_valid, tone_up;
	logic       tone_valid_up, sample_valid, windowed_valid, pack_valid, pack_out_valid;
	logic       activity_flag, speech_frame_flag;
	logic [7:0] sample_index, windowed_index;
	logic [15:0] first_encoded_parameter_in, second_encoded_parameter_in;
	logic [15:0] first_encoded_parameter, second_encoded_parameter;
	tpg_word_t  reflection_coefficient_1, reflection_coefficient_2;
	tpg_word_t  reflection_coefficient_3, reflection_coefficient_4;
	tpg_word_t  sample, windowed_sample;
	int         n_errors = 0, num_checks = 0, cyc = 0, n_up = 0;

	tpg_enc_model enc_u (.ref_clk, .frame_start, .reflection_coefficient_1,
		.reflection_coefficient_2, .reflection_coefficient_3, .reflection_coefficient_4,
		.low_pole, .sample_valid, .sample_index, .sample);
	tpg_stage dut_u (.ref_clk, .arst_n, .frame_start, .reflection_coefficient_1,
		.reflection_coefficient_2, .reflection_coefficient_3, .reflection_coefficient_4,
		.low_pole, .tone, .tone_valid, .sample_valid,
		.sample_index, .sample, .windowed_sample, .windowed_valid, .windowed_index,
		.pack_valid, .activity_flag, .speech_frame_flag, .first_encoded_parameter_in,
		.second_encoded_parameter_in, .first_encoded_parameter,
		.second_encoded_parameter, .pack_out_valid);
	tpg_stage #(.DOWNLINK(1'b0)) dut_up (.ref_clk, .arst_n, .frame_start,
		.reflection_coefficient_1, .reflection_coefficient_2, .reflection_coefficient_3,
		.reflection_coefficient_4, .low_pole,
		.tone(tone_up), .tone_valid(tone_valid_up), .sample_valid, .sample_index,
		.sample, .windowed_sample(), .windowed_valid(), .windowed_index(), .pack_valid,
		.activity_flag, .speech_frame_flag, .first_encoded_parameter_in,
		.second_encoded_parameter_in, .first_encoded_parameter(),
		.second_encoded_parameter(), .pack_out_valid());

	// ****
	// Helpers
	// ****
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	function automatic int sat(input int v);
		return v > 32767 ? 32767 : (v < -32768 ? -32768 : v);
	endfunction
	task automatic check(input string name, input logic [15:0] seen, want);
		num_checks++;
		if (seen !== want) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", name, want, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	always @(negedge ref_clk) begin
		cyc++;
		if (tone_valid_up === 1'b1) begin
			n_up++;
			check("uplink tone", 16'(tone_up), 16'h0000);
		end
		if (cyc == 5000) begin
			n_errors++;
			finish_test();
		end
	end

	// ****
	// Scenarios
	// ****
	task automatic tone_case(input tpg_word_t c [4], input logic lp);
		int e, t;
		logic want;
		e = 32767;
		foreach (c[i]) begin
			t = sat((int'(c[i]) * int'(c[i])) >>> 15);
			t = sat(32767 - t);
			e = sat((e * t) >>> 15);
		end
		want = !lp && (sat(e - 1464) < 0);
		enc_u.send_frame(c, lp);
		if (!lp) repeat (6) @(posedge ref_clk);
		#1;
		check("tone_valid", 16'(tone_valid), 16'h0001);
		check("tone", 16'(tone), 16'(want));
		@(posedge ref_clk) #10;
		check("tone_valid pulse", 16'(tone_valid), 16'h0000);
	endtask
	task automatic win_case(input logic [7:0] idx, input tpg_word_t s, input int h);
		enc_u.send_sample(idx, s);
		@(posedge ref_clk) #1;
		check("windowed_valid", 16'(windowed_valid), 16'h0001);
		check("windowed_index", 16'(windowed_index), 16'(idx));
		check("windowed", windowed_sample, 16'(sat((s * h + 16384) >>> 15)));
		@(posedge ref_clk) #10;
	endtask
	task automatic pack_case(input logic a, sf);
		activity_flag = a;
		speech_frame_flag = sf;
		first_encoded_parameter_in = a ? 16'h0000 : 16'hFFFF;
		second_encoded_parameter_in = sf ? 16'h0000 : 16'hFFFF;
		pack_valid = 1'b1;
		@(posedge ref_clk) #10;
		pack_valid = 1'b0;
		check("pack_out_valid", 16'(pack_out_valid), 16'h0001);
		check("first param", first_encoded_parameter, {a, {15{~a}}});
		check("second param", second_encoded_parameter, {sf, {15{~sf}}});
		@(posedge ref_clk) #10;
		check("pack_out_valid pulse", 16'(pack_out_valid), 16'h0000);
	endtask

	initial begin
		arst_n = 1'b0;
		pack_valid = 1'b0;
		activity_flag = 1'b0;
		speech_frame_flag = 1'b0;
		first_encoded_parameter_in = 16'h0000;
		second_encoded_parameter_in = 16'h0000;
		repeat (5) @(posedge ref_clk);
		check("reset tone_valid", 16'(tone_valid), 16'h0000);
		#10 arst_n = 1'b1;
		tone_case('{default: 16'sh0000}, 1'b0);
		tone_case('{default: 16'sh7000}, 1'b0);
		tone_case('{default: 16'sh7000}, 1'b1);
		tone_case('{16'sh8000, 16'sh0000, 16'sh0000, 16'sh0000}, 1'b0);
		tone_case('{16'sh7D19, 16'sh0000, 16'sh0000, 16'sh0000}, 1'b0);
		tone_case('{16'sh7D1A, 16'sh0000, 16'sh0000, 16'sh0000}, 1'b0);
		win_case(8'h00, 16'sh7FFF, 0);
		win_case(8'h28, 16'sh7FFF, 16545);
		win_case(8'h4F, 16'sh7FFF, 32764);
		win_case(8'h50, 16'sh8000, 32764);
		win_case(8'h77, 16'sh1234, 16545);
		win_case(8'h9F, 16'sh7FFF, 0);
		enc_u.send_sample(8'hA0, 16'sh7FFF);
		repeat (3) begin
			check("refused", 16'(windowed_valid), 16'h0000);
			@(posedge ref_clk) #10;
		end
		for (int k = 0; k < 4; k++) pack_case(k[0], k[1]);
		check("uplink pulses", 16'(n_up), 16'h0006);
		finish_test();
	end
endmodule
`default_nettype wire
